// ---- src/ctt_map.svh ----
/*
 * Constants of the connectivity test logic: widths, minterm indices,
 * device width codes, reset values and pipeline depth.
 * Assumes it is included by bare name wherever a constant is needed.
 */
`ifndef CTT_MAP_SVH
`define CTT_MAP_SVH

// Pin group widths
`define CTT_ADDR_W   17
`define CTT_MT_W     10
`define CTT_DQ_W     16
`define CTT_DQ_HALF  8
`define CTT_X4_USED  4

// Supported device widths
`define CTT_X4       5'h04
`define CTT_X8       5'h08
`define CTT_X16      5'h10

// Minterm indices that feed the strobes
`define CTT_MT_DQS_T 4'h8
`define CTT_MT_DQS_C 4'h9

// Reset values
`define CTT_OE_OFF   1'b1
`define CTT_BIT_RST  1'b0

// Edges from a pin change to the output pins: two sync stages plus output
`define CTT_LATENCY  3

`endif

// ---- src/ctt_pkg.sv ----
/*
 * Types of the connectivity test logic: captured pin set and the packed
 * state of the top module.
 * Assumes ctt_map.svh sits in the include path.
 */
`include "ctt_map.svh"

package ctt_pkg;

    // One sample of every test input pin plus enable and chip select
    typedef struct packed {
        logic                    connectivity_test_enable_pin;
        logic                    cs_n;
        logic [1:0]              ba;
        logic [1:0]              bg;
        logic [`CTT_ADDR_W-1:0]  addr;
        logic                    cke;
        logic                    act_n;
        logic                    odt;
        logic                    ck_t;
        logic                    ck_c;
        logic                    par;
        logic [1:0]              dm_n;
        logic                    alert_n;
        logic                    reset_n;
    } ctt_pins_t;

    // Whole state of the top module
    typedef struct packed {
        ctt_pins_t               s1;
        ctt_pins_t               s2;
        logic [`CTT_DQ_W-1:0]    dq;
        logic [`CTT_DQ_W-1:0]    dq_oe_n;
        logic [1:0]              dqs_t;
        logic [1:0]              dqs_c;
        logic [1:0]              dqs_oe_n;
        logic                    ct_mode;
        logic                    vref_half;
    } ctt_state_t;

endpackage

// ---- src/ctt_if.sv ----
/*
 * Carrier between the test top and its minterm network.
 * Assumes the top drives the synchronised pin set and reads the minterms.
 */
`timescale 1ns/100ps
`include "ctt_map.svh"

interface ctt_if;
    ctt_pkg::ctt_pins_t     pins;
    logic [`CTT_MT_W-1:0]   mt;

    modport src  (output pins, input mt);
    modport calc (input pins, output mt);
endinterface

// ---- src/ctt_minterms.sv ----
/*
 * XOR minterm network of the connectivity test.
 * Assumes pins arrive already synchronised; purely combinational.
 */
`timescale 1ns/100ps
`include "ctt_map.svh"

module ctt_minterms #(
    parameter logic [4:0] DEV_WIDTH = `CTT_X16
) (
    // Pin set in, minterms out
    ctt_if.calc bus
);

    ctt_pkg::ctt_pins_t p;
    assign p = bus.pins;

    // Width independent minterms
    assign bus.mt[0] = p.addr[1] ^ p.addr[6] ^ p.par;                   // see R09
    assign bus.mt[1] = p.addr[8] ^ p.alert_n ^ p.addr[9];               // see R09
    assign bus.mt[2] = p.addr[2] ^ p.addr[5] ^ p.addr[13];              // see R10
    assign bus.mt[3] = p.addr[0] ^ p.addr[7] ^ p.addr[11];              // see R11
    assign bus.mt[4] = p.ck_c ^ p.odt ^ p.addr[15];                     // see R11
    assign bus.mt[5] = p.cke ^ p.addr[16] ^ p.addr[10];                 // see R12
    assign bus.mt[6] = p.act_n ^ p.addr[4] ^ p.ba[1];                   // see R12
    assign bus.mt[8] = p.addr[14] ^ p.addr[12] ^ p.ba[0];               // see R14
    assign bus.mt[9] = p.bg[0] ^ p.addr[3] ^ (p.reset_n & p.connectivity_test_enable_pin);       // see R14

    // Minterm 7 follows the device width
    generate
        if (DEV_WIDTH == `CTT_X16) begin : g_mt7_x16
            assign bus.mt[7] = p.dm_n[1] ^ p.dm_n[0] ^ p.ck_t;          // see R13
        end else if (DEV_WIDTH == `CTT_X8) begin : g_mt7_x8
            assign bus.mt[7] = p.bg[1] ^ p.dm_n[0] ^ p.ck_t;            // see R13
        end else begin : g_mt7_x4
            assign bus.mt[7] = p.bg[1] ^ p.ck_t;                        // see R13
        end
    endgenerate

endmodule

// ---- src/ctt_top.sv ----
/*
 * Connectivity test logic: while the test enable pin is high the memory
 * function is bypassed, the test input pins are sampled in parallel and
 * XOR minterms of them drive the data and strobe pins, gated by chip select.
 * Assumes the core tri-states its pins from the enables here and switches
 * its reference to mid-supply on o_vref_half; every pin is asynchronous.
 */
// How it works
// R01 - Enable high bypasses memory, pins become test
// R02 - Agent keeps enable low in normal use
// R03 - Test mode forces data reference to half
// R04 - Outputs driven only while chip select low
// R05 - Agent holds reset pin high during test
// R06 - All inputs in parallel, fixed-delay outputs
// R07 - Agent fully resets device after test
// R08 - Inputs are command pins, outputs data/strobes
// R09 - Minterm0 A1^A6^PAR, minterm1 A8^ALERT^A9
// R10 - Minterm2 is A2^A5^A13
// R11 - Minterm3 A0^A7^A11, minterm4 CKc^ODT^A15
// R12 - Minterm5 CKE^A16^A10, minterm6 ACT^A4^BA1
// R13 - Minterm7 choice depends on device width
// R14 - Minterm8 A14^A12^BA0, minterm9 BG0^A3^(RST&EN)
// R15 - x4: DQ from minterm pairs, strobes 8/9
// R16 - x8: DQ from minterms 0-7, strobes 8/9
// R17 - x16: upper byte and strobes inverted lower
// R18 - Agent uses test only before initialization
// R19 - No state beyond the fixed delay pipeline
`timescale 1ns/100ps
`include "ctt_map.svh"

module ctt_top #(
    parameter logic [4:0] DEV_WIDTH = `CTT_X16
) (
    // Clock, reset, clock enable
    input  wire logic                   i_sys_clk,
    input  wire logic                   i_nrst,
    input  wire logic                   i_clk_en,
    // Mode and select pins
    input  wire logic                   i_connectivity_test_enable_pin,
    input  wire logic                   i_cs_n,
    // Test input pins
    input  wire logic [1:0]             i_ba,
    input  wire logic [1:0]             i_bg,
    input  wire logic [`CTT_ADDR_W-1:0] i_addr,
    input  wire logic                   i_cke,
    input  wire logic                   i_act_n,
    input  wire logic                   i_odt,
    input  wire logic                   i_ck_t,
    input  wire logic                   i_ck_c,
    input  wire logic                   i_par,
    input  wire logic [1:0]             i_dm_n,
    input  wire logic                   i_alert_n,
    input  wire logic                   i_reset_n,
    // Test output pins
    output logic [`CTT_DQ_W-1:0]        o_dq,
    output logic [`CTT_DQ_W-1:0]        o_dq_oe_n,
    output logic [1:0]                  o_dqs_t,
    output logic [1:0]                  o_dqs_c,
    output logic [1:0]                  o_dqs_oe_n,
    // Core control
    output logic                        o_connectivity_check_mode,
    output logic                        o_vref_half
);

    // Refuse widths that the pin map cannot serve
    generate
        if (DEV_WIDTH != `CTT_X4 && DEV_WIDTH != `CTT_X8 && DEV_WIDTH != `CTT_X16) begin : g_bad
            $error("ctt_top: device width must be 4, 8 or 16");
        end
    endgenerate

    ctt_pkg::ctt_state_t    state_ff;
    ctt_pkg::ctt_state_t    nxt_state;
    ctt_pkg::ctt_pins_t     pin_now;
    logic [`CTT_DQ_HALF-1:0] lo_val;
    logic [`CTT_DQ_HALF-1:0] lo_en;
    logic [`CTT_DQ_HALF-1:0] hi_val;
    logic [`CTT_DQ_HALF-1:0] hi_en;
    logic                   drive_now;
    logic                   upper_on;

    ctt_if u_bus ();

    // Gather every test input pin in one sample
    assign pin_now = '{connectivity_test_enable_pin: i_connectivity_test_enable_pin, cs_n: i_cs_n,   // see R08
                       ba: i_ba, bg: i_bg, addr: i_addr, cke: i_cke,
                       act_n: i_act_n, odt: i_odt, ck_t: i_ck_t, ck_c: i_ck_c,
                       par: i_par, dm_n: i_dm_n, alert_n: i_alert_n,
                       reset_n: i_reset_n};

    // Minterms from the second sync stage only
    assign u_bus.pins = state_ff.s2;

    ctt_minterms #(
        .DEV_WIDTH (DEV_WIDTH)
    ) u_minterms (
        .bus       (u_bus)
    );

    // Pins driven only in test mode with chip select low
    assign drive_now = state_ff.s2.connectivity_test_enable_pin & ~state_ff.s2.cs_n;                 // see R04
    assign upper_on  = (DEV_WIDTH == `CTT_X16);

    // Per-bit data mapping for each width
    genvar b;
    generate
        for (b = 0; b < `CTT_DQ_HALF; b++) begin : g_bit
            if (DEV_WIDTH == `CTT_X4) begin : g_x4
                if (b < `CTT_X4_USED) begin : g_used
                    assign lo_val[b] = u_bus.mt[2*b] ^ u_bus.mt[2*b+1];   // see R15
                    assign lo_en[b]  = 1'b1;
                end else begin : g_unused
                    assign lo_val[b] = 1'b0;
                    assign lo_en[b]  = 1'b0;
                end
            end else begin : g_wide
                assign lo_val[b] = u_bus.mt[b];                             // see R16
                assign lo_en[b]  = 1'b1;
            end
            assign hi_val[b] = upper_on & ~lo_val[b];                       // see R17
            assign hi_en[b]  = upper_on;
        end
    endgenerate

    // Next state: two sync stages then registered pin values
    always_comb begin
        nxt_state = state_ff;
        if (i_clk_en) begin
            nxt_state.s1        = pin_now;                                  // see R06
            nxt_state.s2        = state_ff.s1;
            nxt_state.ct_mode   = state_ff.s2.connectivity_test_enable_pin;                          // see R01
            nxt_state.vref_half = state_ff.s2.connectivity_test_enable_pin;                          // see R03
            nxt_state.dq        = {hi_val, lo_val} & {`CTT_DQ_W{drive_now}}; // see R19
            nxt_state.dq_oe_n   = ~({hi_en, lo_en} & {`CTT_DQ_W{drive_now}});
            nxt_state.dqs_t     = {upper_on & ~u_bus.mt[`CTT_MT_DQS_T],
                                   u_bus.mt[`CTT_MT_DQS_T]} & {2{drive_now}};
            nxt_state.dqs_c     = {upper_on & ~u_bus.mt[`CTT_MT_DQS_C],
                                   u_bus.mt[`CTT_MT_DQS_C]} & {2{drive_now}};
            nxt_state.dqs_oe_n  = ~({upper_on, 1'b1} & {2{drive_now}});     // see R04
        end
    end

    // State register
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_ff          <= '0;
            state_ff.dq_oe_n  <= {`CTT_DQ_W{`CTT_OE_OFF}};
            state_ff.dqs_oe_n <= {2{`CTT_OE_OFF}};
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Outputs straight from the state register
    assign o_dq                      = state_ff.dq;
    assign o_dq_oe_n                 = state_ff.dq_oe_n;
    assign o_dqs_t                   = state_ff.dqs_t;
    assign o_dqs_c                   = state_ff.dqs_c;
    assign o_dqs_oe_n                = state_ff.dqs_oe_n;
    assign o_connectivity_check_mode = state_ff.ct_mode;
    assign o_vref_half               = state_ff.vref_half;

    // Expected values from raw pins, read only by the checks below
    logic exp_drive;
    logic exp_mt0;
    logic exp_mt1;
    logic exp_mt7;
    logic exp_mt8;
    logic exp_mt9;
    logic exp_dq0_x4;
    assign exp_drive = i_connectivity_test_enable_pin & ~i_cs_n;
    assign exp_mt0   = i_addr[1] ^ i_addr[6] ^ i_par;
    assign exp_mt1   = i_addr[8] ^ i_alert_n ^ i_addr[9];
    assign exp_dq0_x4 = exp_mt0 ^ exp_mt1;
    assign exp_mt7   = (DEV_WIDTH == `CTT_X16) ? (i_dm_n[1] ^ i_dm_n[0] ^ i_ck_t) :
                       (DEV_WIDTH == `CTT_X8)  ? (i_bg[1] ^ i_dm_n[0] ^ i_ck_t) :
                                                 (i_bg[1] ^ i_ck_t);
    assign exp_mt8   = i_addr[14] ^ i_addr[12] ^ i_ba[0];
    assign exp_mt9   = i_bg[0] ^ i_addr[3] ^ (i_reset_n & i_connectivity_test_enable_pin);

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_nrst);

    a_cs_high_tristate: assert property (                                   // see R04
        $past(i_clk_en, 1) && $past(i_clk_en, 2) && $past(i_clk_en, 3)
        && $past(i_cs_n, 3) |-> (&o_dq_oe_n) && (&o_dqs_oe_n))
        else $error("outputs driven while chip select high");

    a_cs_low_drive: assert property (                                       // see R04
        $past(i_clk_en, 1) && $past(i_clk_en, 2) && $past(i_clk_en, 3)
        && $past(exp_drive, 3) |-> !o_dqs_oe_n[0] && !o_dq_oe_n[0])
        else $error("outputs not driven in test mode with select low");

    a_vref_half_follow: assert property (                                   // see R03
        $past(i_clk_en, 1) && $past(i_clk_en, 2) && $past(i_clk_en, 3)
        |-> o_vref_half == $past(i_connectivity_test_enable_pin, 3))
        else $error("reference override does not follow test enable");

    a_mode_flag_follow: assert property (                                   // see R01
        i_clk_en [*3] ##1 1'b1 |-> o_connectivity_check_mode
                                   == $past(i_connectivity_test_enable_pin, 3))
        else $error("test mode flag does not follow test enable");

    a_strobe_true_mt8: assert property (                                    // see R14
        $past(i_clk_en, 1) && $past(i_clk_en, 2) && $past(i_clk_en, 3)
        && $past(exp_drive, 3) |-> o_dqs_t[0] == $past(exp_mt8, 3))
        else $error("true strobe differs from minterm 8");

    a_strobe_comp_mt9: assert property (                                    // see R14
        $past(i_clk_en, 1) && $past(i_clk_en, 2) && $past(i_clk_en, 3)
        && $past(exp_drive, 3) |-> o_dqs_c[0] == $past(exp_mt9, 3))
        else $error("complement strobe differs from minterm 9");

    a_dq0_minterm: assert property (                                        // see R09
        $past(i_clk_en, 1) && $past(i_clk_en, 2) && $past(i_clk_en, 3)
        && $past(exp_drive, 3) |-> o_dq[0] == ((DEV_WIDTH == `CTT_X4) ?
                                   $past(exp_dq0_x4, 3) : $past(exp_mt0, 3)))
        else $error("data bit 0 differs from its minterm");

    a_mt7_width: assert property (                                          // see R13
        $past(i_clk_en, 1) && $past(i_clk_en, 2) && $past(i_clk_en, 3)
        && $past(exp_drive, 3) && (DEV_WIDTH != `CTT_X4)
        |-> o_dq[7] == $past(exp_mt7, 3))
        else $error("data bit 7 differs from minterm 7");

    a_upper_inverse: assert property (                                      // see R17
        (DEV_WIDTH == `CTT_X16) && !o_dq_oe_n[0]
        |-> o_dq[15:8] == ~o_dq[7:0] && o_dqs_t[1] == ~o_dqs_t[0]
            && o_dqs_c[1] == ~o_dqs_c[0] && !o_dq_oe_n[8])
        else $error("upper byte or strobes not inverted lower");

    a_x4_upper_off: assert property (                                       // see R15
        (DEV_WIDTH == `CTT_X4) |-> (&o_dq_oe_n[`CTT_DQ_W-1:`CTT_X4_USED]))
        else $error("x4 device drives unused data pins");

endmodule

// ---- dv/ctt_tester.sv ----
/*
 * Board test agent model: drives test enable, chip select and every
 * test input pin of the device in parallel; the pattern word holds all but the reset pin, which stays high.
 * Assumes pins change just after a rising edge of i_sys_clk.
 */
`timescale 1ns/100ps

module ctt_tester (
    // Clock
    input  wire logic        i_sys_clk,
    // Mode and select
    output logic             o_ten,
    output logic             o_cs_n,
    // Pattern {ba,bg,addr,cke,act_n,odt,ck_t,ck_c,par,dm_n,alert_n}
    output logic [29:0]      o_pins,
    output logic             o_reset_n
);
    // Idle: test mode off until the bench asks, reset pin high
    initial begin
        o_ten     = 1'b0;
        o_cs_n    = 1'b1;
        o_pins    = 30'h0;
        o_reset_n = 1'b1;
    end

    // One parallel pattern, launched just after a rising edge
    task automatic apply(input logic connectivity_test_enable_pin, input logic cs_n, input logic [29:0] v);
        @(posedge i_sys_clk);
        o_ten     <= connectivity_test_enable_pin;
        o_cs_n    <= cs_n;
        o_pins    <= v;
        o_reset_n <= 1'b1;
    endtask
endmodule

// ---- dv/tb_ctt_top.sv ----
/*
 * Self-checking bench: one agent drives x16, x8 and x4 instances.
 * Assumes outputs settle within four enabled edges of a pin change.
 */
`timescale 1ns/100ps
`include "ctt_map.svh"

module tb_ctt_top;
    logic        i_sys_clk = 1'b0;
    logic        i_nrst    = 1'b0;
    logic        i_clk_en  = 1'b1;
    logic        connectivity_test_enable_pin;
    logic        cs_n;
    logic        rst_pin;
    logic [29:0] pins;
    logic [15:0] dq [3];
    logic [15:0] dq_oe_n [3];
    logic [1:0]  dqs_t [3];
    logic [1:0]  dqs_c [3];
    logic [1:0]  dqs_oe_n [3];
    logic        mode [3];
    logic        vref [3];
    int          fail_count = 0;
    int          checks = 0;

    // Clock
    always #5 i_sys_clk = ~i_sys_clk;

    ctt_tester ctt_tester_i (.i_sys_clk(i_sys_clk), .o_ten(connectivity_test_enable_pin), .o_cs_n(cs_n),
                             .o_pins(pins), .o_reset_n(rst_pin));

    // Three widths on the same pins
    for (genvar g = 0; g < 3; g++) begin : g_w
        ctt_top #(
            .DEV_WIDTH (g == 0 ? `CTT_X16 : (g == 1 ? `CTT_X8 : `CTT_X4))
        ) ctt_top_i (
            .i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_clk_en(i_clk_en),
            .i_connectivity_test_enable_pin(connectivity_test_enable_pin), .i_cs_n(cs_n),
            .i_ba(pins[29:28]), .i_bg(pins[27:26]), .i_addr(pins[25:9]),
            .i_cke(pins[8]), .i_act_n(pins[7]), .i_odt(pins[6]), .i_ck_t(pins[5]),
            .i_ck_c(pins[4]), .i_par(pins[3]), .i_dm_n(pins[2:1]),
            .i_alert_n(pins[0]), .i_reset_n(rst_pin),
            .o_dq(dq[g]), .o_dq_oe_n(dq_oe_n[g]), .o_dqs_t(dqs_t[g]),
            .o_dqs_c(dqs_c[g]), .o_dqs_oe_n(dqs_oe_n[g]),
            .o_connectivity_check_mode(mode[g]), .o_vref_half(vref[g])
        );
    end

    // Expected pins {dq,dq_oe_n,dqs_t,dqs_c,dqs_oe_n,mode,vref}
    function automatic logic [39:0] exp_out(input int g, input logic t, input logic c,
                                            input logic [29:0] v);
        logic [9:0]  mt;
        logic [16:0] a;
        logic [15:0] d;
        logic [15:0] oe;
        logic [1:0]  st;
        logic [1:0]  sc;
        logic [1:0]  so;
        a = v[25:9];
        mt[0] = a[1] ^ a[6] ^ v[3];
        mt[1] = a[8] ^ v[0] ^ a[9];
        mt[2] = a[2] ^ a[5] ^ a[13];
        mt[3] = a[0] ^ a[7] ^ a[11];
        mt[4] = v[4] ^ v[6] ^ a[15];
        mt[5] = v[8] ^ a[16] ^ a[10];
        mt[6] = v[7] ^ a[4] ^ v[29];
        mt[7] = (g == 0) ? v[2] ^ v[1] ^ v[5] : v[27] ^ v[5] ^ (g == 1 && v[1]);
        mt[8] = a[14] ^ a[12] ^ v[28];
        mt[9] = v[26] ^ a[3] ^ t;
        d  = 16'h0000;
        oe = 16'hFFFF;
        st = 2'b00;
        sc = 2'b00;
        so = 2'b11;
        if (t && !c) begin
            st = {1'b0, mt[8]};
            sc = {1'b0, mt[9]};
            so = 2'b10;
            if (g == 0) begin
                d  = {~mt[7:0], mt[7:0]};
                oe = 16'h0000;
                st = {~mt[8], mt[8]};
                sc = {~mt[9], mt[9]};
                so = 2'b00;
            end else if (g == 1) begin
                d  = {8'h00, mt[7:0]};
                oe = 16'hFF00;
            end else begin
                d  = {12'h000, mt[6] ^ mt[7], mt[4] ^ mt[5], mt[2] ^ mt[3], mt[0] ^ mt[1]};
                oe = 16'hFFF0;
            end
        end
        return {d, oe, st, sc, so, t, t};
    endfunction

    // Compare all three widths
    task automatic check_all(input logic t, input logic c, input logic [29:0] v);
        logic [39:0] got;
        logic [39:0] want;
        for (int g = 0; g < 3; g++) begin
            got  = {dq[g], dq_oe_n[g], dqs_t[g], dqs_c[g], dqs_oe_n[g], mode[g], vref[g]};
            want = exp_out(g, t, c, v);
            checks++;
            if (got !== want) begin
                fail_count++;
                $display("unexpected at %0t: width %0d got %h want %h", $time, g, got, want);
            end
        end
    endtask

    // Apply, let the fixed delay pass, compare
    task automatic run(input logic t, input logic c, input logic [29:0] v);
        ctt_tester_i.apply(t, c, v);
        repeat (4) @(posedge i_sys_clk);
        #1 check_all(t, c, v);
    endtask

    task automatic test_normal();
        run(1'b0, 1'b0, 30'h3FFFFFFF);
    endtask

    task automatic test_walk();
        run(1'b1, 1'b0, 30'h0);
        for (int i = 0; i < 30; i++) begin
            run(1'b1, 1'b0, 30'h1 << i);
        end
        run(1'b1, 1'b0, 30'h2AAAAAAA);
        run(1'b1, 1'b0, 30'h3FFFFFFF);
    endtask

    task automatic test_select();
        run(1'b1, 1'b1, 30'h15555555);
        run(1'b1, 1'b0, 30'h15555555);
    endtask

    // Two patterns on consecutive edges: the first shows for one cycle, then the second
    task automatic test_back_to_back();
        ctt_tester_i.apply(1'b1, 1'b0, 30'h0F0F0F0F);
        ctt_tester_i.apply(1'b1, 1'b0, 30'h30F0F0F0);
        repeat (2) @(posedge i_sys_clk);
        #1 check_all(1'b1, 1'b0, 30'h0F0F0F0F);
        @(posedge i_sys_clk);
        #1 check_all(1'b1, 1'b0, 30'h30F0F0F0);
    endtask

    task automatic test_freeze();
        @(posedge i_sys_clk);
        i_clk_en <= 1'b0;
        ctt_tester_i.apply(1'b1, 1'b0, 30'h00FF00FF);
        repeat (6) @(posedge i_sys_clk);
        #1 check_all(1'b1, 1'b0, 30'h30F0F0F0);
        @(posedge i_sys_clk);
        i_clk_en <= 1'b1;
        repeat (4) @(posedge i_sys_clk);
        #1 check_all(1'b1, 1'b0, 30'h00FF00FF);
    endtask

    task automatic test_exit();
        run(1'b0, 1'b0, 30'h00FF00FF);
        @(posedge i_sys_clk);
        i_nrst <= 1'b0;
        repeat (2) @(posedge i_sys_clk);
        #1 check_all(1'b0, 1'b1, 30'h0);
        @(posedge i_sys_clk);
        i_nrst <= 1'b1;
        run(1'b0, 1'b1, 30'h0);
    endtask

    // Verdict and end of run
    task automatic end_sim();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Watchdog
    initial begin
        #50000;
        fail_count++;
        $display("unexpected at %0t: run did not finish", $time);
        end_sim();
    end

    // Main sequence
    initial begin
        repeat (4) @(posedge i_sys_clk);
        #1 check_all(1'b0, 1'b1, 30'h0);
        @(posedge i_sys_clk);
        i_nrst <= 1'b1;
        test_normal();
        test_walk();
        test_select();
        test_back_to_back();
        test_freeze();
        test_exit();
        end_sim();
    end
endmodule
